// ---- rtl/gst_params.svh ----
// Register map, field positions and reset values for the gated timer.
// Included by the timer and its checker; holds definitions only.
`ifndef GST_PARAMS_SVH
`define GST_PARAMS_SVH
`define GST_OFF_CNT_LO   3'h0
`define GST_OFF_CNT_HI   3'h1
`define GST_OFF_CTRL     3'h2
`define GST_OFF_LINK     3'h3
`define GST_OFF_PIE      3'h4
`define GST_OFF_PIR      3'h5
`define GST_OFF_INTCTL   3'h6
`define GST_OFF_CAPCMP_L 3'h7
`define GST_ADDR_W       4
`define GST_OFF_CAPCMP_H 4'h8
`define GST_OFF_CCPCTL   4'h9
`define GST_RST_CTRL     8'h00
`define GST_RST_LINK     8'h02
`define GST_RST_PIE      8'h00
`define GST_RST_PIR      8'h00
`define GST_RST_INTCTL   8'h00
`define GST_RST_CCPCTL   8'h00
`define GST_BIT_ON       0
`define GST_BIT_CS       1
`define GST_BIT_NOSYNC   2
`define GST_BIT_OSCEN    3
`define GST_BIT_PS_LO    4
`define GST_BIT_PS_HI    5
`define GST_BIT_GE       6
`define GST_BIT_GINV     7
`define GST_BIT_GSS      1
`define GST_BIT_OVF      0
`define GST_BIT_PERIPHERAL_INTERRUPT_ENABLE     6
`define GST_BIT_GIE      7
`define GST_BIT_CAPMODE  0
`define GST_BIT_CMPMODE  1
`define GST_BIT_SPECIAL  2
`define GST_CNT_MAX      16'hFFFF
`define GST_CNT_ZERO     16'h0000
`define GST_ISR_VECTOR   16'h0004
`endif

// ---- rtl/gst_pkg.sv ----
// Types used by the gated timer only.
// Assumes gst_params.svh is on the include path.
package gst_pkg;
  typedef struct packed {
    logic       gatePolarity;
    logic       gateEnable;
    logic [1:0] prescaleSelect;
    logic       crystalOscillatorEnable;
    logic       externalSyncDisable;
    logic       clockSourceSelect;
    logic       counterOn;
  } gst_ctrl_t;

  typedef enum logic [2:0] {
    GST_EDGE_ARM  = 3'b001,
    GST_EDGE_LOW  = 3'b010,
    GST_EDGE_RUN  = 3'b100
  } gst_edge_t;
endpackage

// ---- rtl/gst_timer.sv ----
// Gated 16-bit timer with prescaler, overflow flag, wake and capture/compare.
// Assumes a 40 MHz clk, inputs synchronous to clk, one-cycle register strobes.
//
// Functional notes
// - Byte reads return a coherent count value, also in asynchronous counting.
// - Gate comes from pin or comparator per source select, only when gated.
// - Gate enable ignored when off; when on, 1 means count only while gated.
// - Gate polarity 1 counts while gate high, 0 while gate low.
// - Count wraps FFFFh to 0000h and sets the overflow flag.
// - Interrupt needs overflow, peripheral and global enables; flag sticks.
// - Counts in sleep only in async external mode; overflow then wakes.
// - After wake the core resumes, then vectors to 0004h if global enable.
// - Capture mode copies the count into the capture/compare pair on event.
// - Compare mode fires an event when pair equals the count.
// - Special event trigger clears the count without setting the flag.
// - A count write in the same cycle as the trigger wins over the clear.
// - Prescale field divides by 1, 2, 4 or 8.
// - Crystal oscillator enable acts only with internal osc, no clock out.
// - Sync bit: external input unsynchronised at 1, synchronised at 0.
// - Clock source 1 counts external rising edges, 0 the instruction clock.
// - On bit runs the counter; control register resets to zero.
// - External mode needs a falling edge before the first counted rise.
// - Any count byte write also clears the hidden prescale counter.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "gst_params.svh"

module gst_timer #(
  parameter int CNT_W  = 16,
  parameter int DATA_W = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [`GST_ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0]    regWrData,
  input  wire logic                 regWrStb,
  input  wire logic                 regRdStb,
  output logic      [DATA_W-1:0]    regRdData,
  input  wire logic                 instrTick,
  input  wire logic                 externalClockPin,
  input  wire logic                 crystalClock,
  input  wire logic                 gatePin,
  input  wire logic                 comparatorOutput,
  input  wire logic                 internalOscNoClkout,
  input  wire logic                 sleepMode,
  input  wire logic                 captureEvent,
  output logic                      overflowIrq,
  output logic                      wakeRequest,
  output logic                      vectorRequest,
  output logic      [CNT_W-1:0]     vectorAddress,
  output logic                      compareEvent,
  output logic                      crystalOscRun
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  gst_pkg::gst_ctrl_t ctrl_q;
  logic [7:0]         link_q;
  logic [7:0]         pie_q;
  logic [7:0]         pir_q;
  logic [7:0]         intCtl_q;
  logic [7:0]         ccpCtl_q;
  logic [CNT_W-1:0]   count_q;
  logic [CNT_W-1:0]   capCmp_q;
  logic [2:0]         presc_q;
  logic               extSync1_q;
  logic               extSync2_q;
  logic               extPrev_q;
  logic               wakePend_q;
  gst_pkg::gst_edge_t edge_q;

  logic               cntWrLo;
  logic               cntWrHi;
  logic               cntWr;
  logic               srcLevel;
  logic               srcRise;
  logic               srcFall;
  logic               gateRaw;
  logic               gateActive;
  logic               runEn;
  logic               prescPulse;
  logic               countStep;
  logic               rollover;
  logic               cmpMatch;
  logic               specialClr;
  logic [2:0]         prescMask;

  assign cntWrLo = regWrStb && (regAddr == {1'b0, `GST_OFF_CNT_LO});
  assign cntWrHi = regWrStb && (regAddr == {1'b0, `GST_OFF_CNT_HI});
  assign cntWr   = cntWrLo || cntWrHi;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection
  // Crystal only when the internal oscillator runs without clock out
  assign crystalOscRun = ctrl_q.crystalOscillatorEnable && internalOscNoClkout;

  // Two-stage sync; the raw path models the unsynchronised counter input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
    end else begin
      extSync1_q <= crystalOscRun ? crystalClock : externalClockPin;
      extSync2_q <= extSync1_q;
    end
  end

  // Unsynchronised mode still samples once; a real async path has no edge here
  assign srcLevel = ctrl_q.externalSyncDisable ?
                    (crystalOscRun ? crystalClock : externalClockPin) : extSync2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= srcLevel;
    end
  end

  assign srcRise = srcLevel && !extPrev_q;
  assign srcFall = !srcLevel && extPrev_q;

  // Falling edge must be seen after enable or count write before first rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_q <= gst_pkg::GST_EDGE_ARM;
    end else begin
      case (edge_q)
        gst_pkg::GST_EDGE_ARM: begin
          if (srcFall) begin
            edge_q <= gst_pkg::GST_EDGE_RUN;
          end
        end
        gst_pkg::GST_EDGE_LOW: begin
          edge_q <= gst_pkg::GST_EDGE_RUN;
        end
        gst_pkg::GST_EDGE_RUN: begin
          if (cntWr || !ctrl_q.counterOn) begin
            edge_q <= gst_pkg::GST_EDGE_ARM;
          end
        end
        default: begin
          edge_q <= gst_pkg::GST_EDGE_ARM;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate and enable
  assign gateRaw    = link_q[`GST_BIT_GSS] ? comparatorOutput : gatePin;
  // Polarity applies to either source
  assign gateActive = ctrl_q.gatePolarity ? gateRaw : !gateRaw;
  // Gate enable only matters once the on bit is set
  assign runEn = ctrl_q.counterOn && (!ctrl_q.gateEnable || gateActive);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  // Sleep stops the instruction clock; only async external counting survives
  always_comb begin
    if (ctrl_q.clockSourceSelect) begin
      prescPulse = srcRise && (edge_q == gst_pkg::GST_EDGE_RUN) &&
                   (!sleepMode || ctrl_q.externalSyncDisable);
    end else begin
      prescPulse = instrTick && !sleepMode;
    end
  end

  always_comb begin
    case (ctrl_q.prescaleSelect)
      2'b00:   prescMask = 3'h0;
      2'b01:   prescMask = 3'h1;
      2'b10:   prescMask = 3'h3;
      default: prescMask = 3'h7;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= 3'h0;
    end else if (cntWr) begin
      presc_q <= 3'h0;
    end else if (runEn && prescPulse) begin
      presc_q <= (presc_q & prescMask) == prescMask ? 3'h0 : presc_q + 3'h1;
    end
  end

  assign countStep  = runEn && prescPulse && ((presc_q & prescMask) == prescMask);
  assign rollover   = countStep && (count_q == `GST_CNT_MAX);
  assign cmpMatch   = ccpCtl_q[`GST_BIT_CMPMODE] && (capCmp_q == count_q);
  assign specialClr = cmpMatch && ccpCtl_q[`GST_BIT_SPECIAL];

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  // Counter is clk-synchronous, so byte reads are always coherent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `GST_CNT_ZERO;
    end else if (cntWrLo) begin
      count_q <= {count_q[CNT_W-1:8], regWrData};
    end else if (cntWrHi) begin
      count_q <= {regWrData, count_q[7:0]};
    end else if (specialClr) begin
      count_q <= `GST_CNT_ZERO;
    end else if (countStep) begin
      count_q <= count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture/compare pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capCmp_q <= `GST_CNT_ZERO;
    end else if (ccpCtl_q[`GST_BIT_CAPMODE] && captureEvent) begin
      capCmp_q <= count_q;
    end else if (regWrStb && regAddr == {1'b0, `GST_OFF_CAPCMP_L}) begin
      capCmp_q <= {capCmp_q[CNT_W-1:8], regWrData};
    end else if (regWrStb && regAddr == `GST_OFF_CAPCMP_H) begin
      capCmp_q <= {regWrData, capCmp_q[7:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compareEvent <= 1'b0;
    end else begin
      compareEvent <= cmpMatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= `GST_RST_CTRL;
      link_q   <= `GST_RST_LINK;
      pie_q    <= `GST_RST_PIE;
      intCtl_q <= `GST_RST_INTCTL;
      ccpCtl_q <= `GST_RST_CCPCTL;
    end else if (regWrStb) begin
      case (regAddr)
        {1'b0, `GST_OFF_CTRL}:   ctrl_q   <= regWrData;
        {1'b0, `GST_OFF_LINK}:   link_q   <= regWrData;
        {1'b0, `GST_OFF_PIE}:    pie_q    <= regWrData;
        {1'b0, `GST_OFF_INTCTL}: intCtl_q <= regWrData;
        `GST_OFF_CCPCTL:         ccpCtl_q <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // Flag register; a rollover in the same cycle beats a software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pir_q <= `GST_RST_PIR;
    end else if (rollover) begin
      pir_q <= (regWrStb && regAddr == {1'b0, `GST_OFF_PIR} ? regWrData : pir_q) |
               8'h01;
    end else if (regWrStb && regAddr == {1'b0, `GST_OFF_PIR}) begin
      pir_q <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, wake and vector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflowIrq   <= 1'b0;
      wakeRequest   <= 1'b0;
      wakePend_q    <= 1'b0;
      vectorRequest <= 1'b0;
      vectorAddress <= `GST_CNT_ZERO;
    end else begin
      overflowIrq   <= pir_q[`GST_BIT_OVF] && pie_q[`GST_BIT_OVF] &&
                       intCtl_q[`GST_BIT_PERIPHERAL_INTERRUPT_ENABLE] && intCtl_q[`GST_BIT_GIE];
      wakeRequest   <= sleepMode && ctrl_q.counterOn && pir_q[`GST_BIT_OVF] &&
                       pie_q[`GST_BIT_OVF] && intCtl_q[`GST_BIT_PERIPHERAL_INTERRUPT_ENABLE];
      // Vector two cycles after wake, leaving room for the next instruction
      wakePend_q    <= wakeRequest;
      vectorRequest <= wakePend_q && intCtl_q[`GST_BIT_GIE];
      vectorAddress <= `GST_ISR_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      case (regAddr)
        {1'b0, `GST_OFF_CNT_LO}:   regRdData <= count_q[7:0];
        {1'b0, `GST_OFF_CNT_HI}:   regRdData <= count_q[CNT_W-1:8];
        {1'b0, `GST_OFF_CTRL}:     regRdData <= ctrl_q;
        {1'b0, `GST_OFF_LINK}:     regRdData <= {link_q[7:1], comparatorOutput};
        {1'b0, `GST_OFF_PIE}:      regRdData <= pie_q;
        {1'b0, `GST_OFF_PIR}:      regRdData <= pir_q;
        {1'b0, `GST_OFF_INTCTL}:   regRdData <= intCtl_q;
        {1'b0, `GST_OFF_CAPCMP_L}: regRdData <= capCmp_q[7:0];
        `GST_OFF_CAPCMP_H:         regRdData <= capCmp_q[CNT_W-1:8];
        `GST_OFF_CCPCTL:           regRdData <= ccpCtl_q;
        default:                   regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

// ---- verif/gst_timer_sva.sv ----
// Port-level checker for the gated timer.
// Assumes gst_params.svh on the include path; bound to every gst_timer.
`timescale 1ns/10ps
`include "gst_params.svh"
module gst_timer_sva #(
  parameter int CNT_W = 16
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [3:0]       regAddr,
  input wire logic [7:0]       regWrData,
  input wire logic             regWrStb,
  input wire logic             regRdStb,
  input wire logic [7:0]       regRdData,
  input wire logic             internalOscNoClkout,
  input wire logic             sleepMode,
  input wire logic             overflowIrq,
  input wire logic             wakeRequest,
  input wire logic             vectorRequest,
  input wire logic [CNT_W-1:0] vectorAddress,
  input wire logic             compareEvent,
  input wire logic             crystalOscRun
);
  logic [7:0] ctrlQ;
  logic [7:0] pieQ;
  logic [7:0] intQ;
  logic [7:0] ccpQ;
  logic       irqEnAll;
  ////////////////////////////////////////////////////////////////
  // Shadow enables, so no internal probes are needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ <= 8'h00;
      pieQ  <= 8'h00;
      intQ  <= 8'h00;
      ccpQ  <= 8'h00;
    end else if (regWrStb) begin
      if (regAddr == 4'(`GST_OFF_CTRL)) ctrlQ <= regWrData;
      if (regAddr == 4'(`GST_OFF_PIE)) pieQ <= regWrData;
      if (regAddr == 4'(`GST_OFF_INTCTL)) intQ <= regWrData;
      if (regAddr == `GST_OFF_CCPCTL) ccpQ <= regWrData;
    end
  end
  assign irqEnAll = intQ[7] & intQ[6] & pieQ[0];
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_rd_idle_zero: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not zero outside its slot");
  a_rd_ctrl_back: assert property (regRdStb && regAddr == 4'(`GST_OFF_CTRL) |=> regRdData == ctrlQ)
    else $error("control read differs from last write");
  a_osc_int_only: assert property (crystalOscRun == (ctrlQ[3] && internalOscNoClkout))
    else $error("crystal oscillator run mismatch");
  a_vec_fixed: assert property ($past(rst_n) |-> vectorAddress == `GST_ISR_VECTOR)
    else $error("vector address wrong");
  a_vec_after_wake: assert property ($rose(wakeRequest) && intQ[7] |-> ##2 vectorRequest)
    else $error("no vector after wake");
  a_irq_all_enables: assert property (overflowIrq |-> irqEnAll || $past(irqEnAll))
    else $error("interrupt without all enables");
  a_wake_in_sleep: assert property (wakeRequest |-> (sleepMode || $past(sleepMode)) && (ctrlQ[0] || $past(ctrlQ[0])))
    else $error("wake outside sleep or while off");
  a_cmp_mode_only: assert property (compareEvent |-> ccpQ[1] || $past(ccpQ[1]))
    else $error("compare event outside compare mode");
  c_wake: cover property (wakeRequest ##2 vectorRequest);
  c_irq: cover property (overflowIrq);
  c_cmp: cover property (compareEvent);
endmodule
bind gst_timer gst_timer_sva #(.CNT_W(CNT_W)) gst_timer_sva_i (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .internalOscNoClkout(internalOscNoClkout), .sleepMode(sleepMode),
  .overflowIrq(overflowIrq), .wakeRequest(wakeRequest), .vectorRequest(vectorRequest),
  .vectorAddress(vectorAddress), .compareEvent(compareEvent), .crystalOscRun(crystalOscRun)
);

// ---- verif/gst_ext_src.sv ----
// Far-side clock source feeding the external count pin.
// Assumes the bench holds run high for a whole burst.
`timescale 1ns/10ps
module gst_ext_src #(
  parameter int HALF = 3
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      pinLevel,
  output int        rises
);
  int phase;
  initial begin
    pinLevel = 1'b0;
    rises = 0;
    phase = 0;
  end
  // Toggle inside a burst; stand low between bursts, never free-running
  always @(posedge clk) begin
    if (!run) begin
      pinLevel <= 1'b0;
      phase <= 0;
    end else if (phase == HALF - 1) begin
      pinLevel <= !pinLevel;
      rises <= rises + (pinLevel ? 0 : 1);
      phase <= 0;
    end else begin
      phase <= phase + 1;
    end
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the gated timer.
// Assumes gst_timer and the external source model are compiled first.
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic        instrTick = 1'b0;
  logic        gatePin = 1'b0;
  logic        cmpOut = 1'b0;
  logic        internal_oscillator = 1'b0;
  logic        sleepMode = 1'b0;
  logic        captureEvent = 1'b0;
  logic        extRun = 1'b0;
  logic [7:0]  regRdData;
  logic [7:0]  rdv;
  logic        extPin, overflowIrq, wakeRequest, vectorRequest, compareEvent, crystalOscRun;
  logic [15:0] vectorAddress;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          extRises;
  int          r0;
  logic [7:0]  rstVal [10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00};
  // Gate cases: ctrl, link, cmp/pin, ticks counted out of four
  // Source select bit set picks the comparator, clear picks the pin
  logic [31:0] gTab [8] = '{32'h4100_0100, 32'h4100_0004, 32'hC100_0104, 32'hC100_0000,
                             32'hC102_0204, 32'hC102_0100, 32'h4002_0000, 32'h0102_0004};
  ////////////////////////////////////////////////////////////////
  gst_timer gst_timer_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .instrTick(instrTick), .externalClockPin(extPin), .crystalClock(1'b0),
    .gatePin(gatePin), .comparatorOutput(cmpOut), .internalOscNoClkout(internal_oscillator),
    .sleepMode(sleepMode), .captureEvent(captureEvent), .overflowIrq(overflowIrq),
    .wakeRequest(wakeRequest), .vectorRequest(vectorRequest),
    .vectorAddress(vectorAddress), .compareEvent(compareEvent), .crystalOscRun(crystalOscRun)
  );
  gst_ext_src gst_ext_src_i (.clk(clk), .run(extRun), .pinLevel(extPin), .rises(extRises));
  // Clock and hang guard
  always #12.5 clk = !clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Idle cycle after each strobe keeps one assignment per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chkReg(input logic [3:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    // Sample mid-cycle while the read data stand, clear of the edge race
    @(negedge clk);
    rdv = regRdData;
    chk(rdv, exp);
    @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      instrTick <= 1'b1;
      @(posedge clk);
      instrTick <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic setCount(input logic [15:0] v);
    wr(4'h0, v[7:0]);
    wr(4'h1, v[15:8]);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rstVal[i]) chkReg(4'(i), rstVal[i]);
    wr(4'hF, 8'hFF);
    chkReg(4'hF, 8'h00);
    // Each prescale ratio over sixteen ticks
    for (int k = 0; k < 4; k++) begin
      setCount(16'h0000);
      wr(4'h2, 8'(k << 4) | 8'h01);
      tick(16);
      wr(4'h2, 8'h00);
      chkReg(4'h0, 8'(16 >> k));
    end
    // Rollover with all enables, then software clear of the flag
    setCount(16'h0000);
    wr(4'h4, 8'h01);
    wr(4'h6, 8'hC0);
    setCount(16'hFFFF);
    wr(4'h2, 8'h01);
    tick(1);
    wr(4'h2, 8'h00);
    chkReg(4'h1, 8'h00);
    chkReg(4'h5, 8'h01);
    chk(overflowIrq, 1'b1);
    wr(4'h5, 8'h00);
    chkReg(4'h5, 8'h00);
    foreach (gTab[i]) begin
      gatePin <= gTab[i][8];
      cmpOut <= gTab[i][9];
      wr(4'h3, gTab[i][23:16]);
      setCount(16'h0000);
      wr(4'h2, gTab[i][31:24]);
      tick(4);
      wr(4'h2, 8'h00);
      chkReg(4'h0, gTab[i][7:0]);
    end
    wr(4'h2, 8'h08);
    internal_oscillator <= 1'b1;
    @(negedge clk);
    chk(crystalOscRun, 1'b1);
    @(posedge clk);
    internal_oscillator <= 1'b0;
    @(negedge clk);
    chk(crystalOscRun, 1'b0);
    @(posedge clk);
    // Synchronised external count; ticks meanwhile must be ignored
    setCount(16'h0000);
    wr(4'h2, 8'h03);
    r0 = extRises;
    extRun <= 1'b1;
    tick(30);
    extRun <= 1'b0;
    repeat (6) @(posedge clk);
    wr(4'h2, 8'h00);
    chkReg(4'h0, 8'(extRises - r0 - 1));
    // Asleep: internal ticks stop, unsynchronised external wakes
    setCount(16'hFFFE);
    sleepMode <= 1'b1;
    wr(4'h2, 8'h01);
    tick(4);
    chkReg(4'h0, 8'hFE);
    wr(4'h2, 8'h07);
    extRun <= 1'b1;
    repeat (40) @(posedge clk);
    chk(wakeRequest, 1'b1);
    chk(vectorRequest, 1'b1);
    chk(vectorAddress, 16'h0004);
    sleepMode <= 1'b0;
    extRun <= 1'b0;
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h00);
    // Capture, then compare with the special clear
    setCount(16'h1234);
    wr(4'h9, 8'h01);
    captureEvent <= 1'b1;
    @(posedge clk);
    captureEvent <= 1'b0;
    chkReg(4'h7, 8'h34);
    chkReg(4'h8, 8'h12);
    wr(4'h7, 8'h05);
    wr(4'h8, 8'h00);
    setCount(16'h0000);
    wr(4'h9, 8'h06);
    wr(4'h2, 8'h01);
    tick(5);
    repeat (4) @(posedge clk);
    wr(4'h2, 8'h00);
    chkReg(4'h0, 8'h00);
    chkReg(4'h5, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h0, 8'h33);
    chkReg(4'h0, 8'h33);
    wrap_up();
  end
endmodule
